// ==== verilog/swc_wakeup_ctrl.sv ====
// Standby wakeup control with APB register bank and interrupt.
//
// Operation
// - Radio field: 00 if enabled, 10 always, 11 ignore.
// - Tick field: 00 if enabled, 10 always, 11 ignore.
// - Pin field: 00 if enabled, 10 always, 11 ignore.
// - Misc field: 00 if enabled, 10 always, 11 ignore.
// - Wake selections act only during standby.
// - Misc interrupt from oscillator, converter or random unit.
// - Two pin enable registers, reset zero.
// - Pins absent in package never wake.
// - Marked pins selectable polarity, others active high.
// - Enabled serial slave select wakes when low.
// - Polarity bit set makes subset active low.
// - Wake flags pin, tick, comparator clear on read.
`timescale 1ns/10ps
`include "swc_defines.svh"
`default_nettype none

module swc_wakeup_ctrl #(
  parameter swc_pkg::swc_variant_e PKG_VARIANT = swc_pkg::SWC_PKG_BIG
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SWC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [7:0]             irq_enable_second,
  input  wire logic [7:0]             serial_slave_control_first,
  input  wire logic                   serial_slave_select_n,
  input  wire logic [15:0]            wake_pins,
  input  wire logic                   radio_irq,
  input  wire logic                   tick_pulse,
  input  wire logic                   comparator_wake,
  input  wire logic                   fast_crystal_osc_ready,
  input  wire logic                   adc_data_ready,
  input  wire logic                   rng_ready,
  output var  logic                   misc_irq_a,
  output var  logic                   pin_wake_irq,
  output var  logic                   cpu_clk_stop,
  output logic                        irq
);

  // ********************************************************************
  // Elaboration check
  // ********************************************************************

  // The fourth variant code has no pin table behind it.
  if (PKG_VARIANT != swc_pkg::SWC_PKG_BIG &&
      PKG_VARIANT != swc_pkg::SWC_PKG_MID &&
      PKG_VARIANT != swc_pkg::SWC_PKG_SMALL) begin : g_bad_variant
    $error("Unsupported package variant.");
  end

  // ********************************************************************
  // Functions
  // ********************************************************************

  // A source wakes when its code says always, or conditional and enabled.
  // The reserved code is treated as ignore so it can never wake by chance.
  function automatic logic swc_qual(input logic [1:0] code,
                                    input logic       ien,
                                    input logic       ev);
    swc_qual = ev & ((code == swc_pkg::SWC_ALWAYS) |
                     ((code == swc_pkg::SWC_COND) & ien));
  endfunction

  // Word-aligned address match against a register index.
  function automatic logic swc_hit(input logic [`SWC_ADDR_W-1:0] addr,
                                   input logic [7:0]             idx);
    swc_hit = (addr[`SWC_ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // ********************************************************************
  // Registers
  // ********************************************************************

  logic [7:0]          wss_ff;
  logic [7:0]          pwh_ff;
  logic [7:0]          pwl_ff;
  logic [7:0]          omc_ff;
  logic [2:0]          pd_stat_ff;
  logic [2:0]          pd_mode_ff;
  logic [2:0]          ist_ff;
  logic [2:0]          ien_ff;
  logic                cap_ff;
  swc_pkg::swc_state_e state_ff;

  // ********************************************************************
  // APB decode
  // ********************************************************************

  // Read data is captured in the setup cycle so prdata comes from a flop;
  // the access phase then completes at once while the clock is enabled.
  wire hit_pdc  = swc_hit(paddr, `SWC_IDX_PDC);
  wire hit_wss  = swc_hit(paddr, `SWC_IDX_WSS);
  wire hit_omc  = swc_hit(paddr, `SWC_IDX_OMC);
  wire hit_pwh  = swc_hit(paddr, `SWC_IDX_PWH);
  wire hit_pwl  = swc_hit(paddr, `SWC_IDX_PWL);
  wire hit_ist  = swc_hit(paddr, `SWC_IDX_IST);
  wire hit_ien  = swc_hit(paddr, `SWC_IDX_IEN);
  wire hit_icl  = swc_hit(paddr, `SWC_IDX_ICL);
  wire hit_any  = hit_pdc | hit_wss | hit_omc | hit_pwh | hit_pwl |
                  hit_ist | hit_ien | hit_icl;
  wire setup_w  = ce & psel & ~penable;
  wire done_w   = ce & psel & penable & cap_ff;
  wire wr_w     = done_w & pwrite & hit_any;
  wire rd_w     = done_w & ~pwrite & hit_any;

  assign pready  = psel & penable & ce & cap_ff;
  assign pslverr = pready & ~hit_any;

  // Read selection; reserved bits and the clear register read as zero.
  wire [7:0] rd_mux =
    hit_pdc ? {pd_stat_ff, 2'b00, pd_mode_ff} :
    hit_wss ? wss_ff :
    hit_omc ? (omc_ff & `SWC_OMC_MASK) :
    hit_pwh ? pwh_ff :
    hit_pwl ? pwl_ff :
    hit_ist ? {5'h00, ist_ff} :
    hit_ien ? {5'h00, ien_ff} :
    `SWC_RST8;

  // Write strobes per register.
  wire wr_pdc = wr_w & hit_pdc;
  wire wr_wss = wr_w & hit_wss;
  wire wr_omc = wr_w & hit_omc;
  wire wr_pwh = wr_w & hit_pwh;
  wire wr_pwl = wr_w & hit_pwl;
  wire wr_ien = wr_w & hit_ien;
  wire wr_icl = wr_w & hit_icl;

  // ********************************************************************
  // Pin wakeup
  // ********************************************************************

  // Presence and polarity tables follow the chosen package.
  wire [15:0] pin_mask_w =
    (PKG_VARIANT == swc_pkg::SWC_PKG_MID)   ? `SWC_PMASK_MID :
    (PKG_VARIANT == swc_pkg::SWC_PKG_SMALL) ? `SWC_PMASK_SMALL :
    `SWC_PMASK_BIG;
  wire [15:0] pol_mask_w =
    (PKG_VARIANT == swc_pkg::SWC_PKG_MID)   ? `SWC_POL_MID :
    (PKG_VARIANT == swc_pkg::SWC_PKG_SMALL) ? `SWC_POL_SMALL :
    `SWC_POL_BIG;

  // Enabled pins; bits without a pin are dropped by the mask.
  wire [15:0] pin_en_w  = {pwh_ff, pwl_ff} & pin_mask_w;
  // Only the marked pins invert when the polarity bit is set.
  wire        low_pol_w = omc_ff[`SWC_OMC_POL];
  wire [15:0] pin_lvl_w = wake_pins ^ (pol_mask_w & {16{low_pol_w}});
  // The serial slave select joins as an active-low source when enabled.
  wire        spi_wk_w  = serial_slave_control_first[`SWC_SPI_EN] &
                          ~serial_slave_select_n;
  wire        pin_hit_w = (|(pin_en_w & pin_lvl_w)) | spi_wk_w;

  // ********************************************************************
  // Wake qualification
  // ********************************************************************

  wire standby_w  = (state_ff == swc_pkg::SWC_STANDBY);
  wire wk_radio_w = swc_qual(wss_ff[`SWC_F_RADIO],
                    irq_enable_second[`SWC_IEN_RADIO], radio_irq);
  wire wk_tick_w  = swc_qual(wss_ff[`SWC_F_TICK],
                    irq_enable_second[`SWC_IEN_TICK], tick_pulse);
  wire wk_pin_w   = swc_qual(wss_ff[`SWC_F_PIN],
                    irq_enable_second[`SWC_IEN_PIN], pin_wake_irq);
  wire wk_misc_w  = swc_qual(wss_ff[`SWC_F_MISC],
                    irq_enable_second[`SWC_IEN_MISC], misc_irq_a);
  // Selections matter only while the processor clock is stopped.
  wire wake_w     = standby_w & (wk_radio_w | wk_tick_w |
                    wk_pin_w | wk_misc_w);

  // Entering any power-down mode is a write with a nonzero mode.
  wire [2:0] wr_mode_w = pwdata[`SWC_PDC_MODE];
  wire enter_pd_w = wr_pdc & (wr_mode_w != `SWC_MODE_NONE);
  wire enter_sb_w = wr_pdc & (wr_mode_w == `SWC_MODE_STANDBY);

  // ********************************************************************
  // Next values
  // ********************************************************************

  // Standby ends on a qualified wake; it is entered only from run.
  swc_pkg::swc_state_e nxt_state;
  assign nxt_state =
    (standby_w & wake_w) ? swc_pkg::SWC_RUN :
    (~standby_w & enter_sb_w) ? swc_pkg::SWC_STANDBY :
    state_ff;

  // Wake flags: a read or a power-down entry clears, a new wake wins.
  wire [2:0] pd_set_w = {standby_w & wk_pin_w, standby_w & wk_tick_w,
                         comparator_wake};
  wire       pd_clr_w = (rd_w & hit_pdc) | enter_pd_w;
  wire [2:0] nxt_pd_stat = (pd_clr_w ? `SWC_RST3 : pd_stat_ff) |
                           pd_set_w;
  wire [2:0] nxt_pd_mode = wr_pdc ? wr_mode_w : pd_mode_ff;

  // Interrupt events; a clear in the same cycle as an event loses.
  wire [2:0] ev_w;
  assign ev_w[`SWC_EV_WAKE] = wake_w;
  assign ev_w[`SWC_EV_PIN]  = pin_wake_irq;
  assign ev_w[`SWC_EV_MISC] = misc_irq_a;
  wire [2:0] icl_w   = wr_icl ? pwdata[2:0] : `SWC_RST3;
  wire [2:0] nxt_ist = (ist_ff & ~icl_w) | ev_w;

  assign irq = |(ist_ff & ien_ff);

  // ********************************************************************
  // Flip-flops
  // ********************************************************************

  // Software registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wss_ff <= `SWC_RST8;
      pwh_ff <= `SWC_RST8;
      pwl_ff <= `SWC_RST8;
      omc_ff <= `SWC_RST8;
      ien_ff <= `SWC_RST3;
    end else if (ce) begin
      if (wr_wss) wss_ff <= pwdata[7:0];
      if (wr_pwh) pwh_ff <= pwdata[7:0];
      if (wr_pwl) pwl_ff <= pwdata[7:0];
      if (wr_omc) omc_ff <= pwdata[7:0] & `SWC_OMC_MASK;
      if (wr_ien) ien_ff <= pwdata[2:0];
    end
  end

  // Block state and flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= swc_pkg::SWC_RUN;
      pd_stat_ff <= `SWC_RST3;
      pd_mode_ff <= `SWC_RST3;
      ist_ff     <= `SWC_RST3;
    end else if (ce) begin
      state_ff   <= nxt_state;
      pd_stat_ff <= nxt_pd_stat;
      pd_mode_ff <= nxt_pd_mode;
      ist_ff     <= nxt_ist;
    end
  end

  // Interrupt lines and clock stop, registered to keep them glitch free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_irq_a   <= 1'b0;
      pin_wake_irq <= 1'b0;
      cpu_clk_stop <= 1'b0;
    end else if (ce) begin
      misc_irq_a   <= fast_crystal_osc_ready | adc_data_ready |
                      rng_ready;
      pin_wake_irq <= pin_hit_w;
      cpu_clk_stop <= (nxt_state == swc_pkg::SWC_STANDBY);
    end
  end

  // Read capture in the setup cycle, released when the transfer ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      cap_ff <= 1'b0;
    end else if (ce) begin
      if (setup_w) prdata <= {24'h00_0000, rd_mux};
      cap_ff <= setup_w | (cap_ff & ~done_w);
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************

  // A completed write of the standby mode from run.
  sequence s_enter_sb;
    ce && ~standby_w && enter_sb_w;
  endsequence

  // A qualified radio wake while standing by with the clock enabled.
  sequence s_radio_wake;
    ce && standby_w && radio_irq &&
    (wss_ff[`SWC_F_RADIO] == swc_pkg::SWC_ALWAYS);
  endsequence

  a_enter_standby: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_enter_sb |=> standby_w && cpu_clk_stop)
    else $error("Standby not entered after mode write.");

  a_radio_always: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_radio_wake |=> !standby_w && !cpu_clk_stop)
    else $error("Radio wake did not end standby.");

  a_tick_ignore: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wss_ff[`SWC_F_TICK] == swc_pkg::SWC_IGNORE) && tick_pulse
    |-> !wk_tick_w)
    else $error("Ignored tick qualified as wake.");

  a_pin_cond: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wss_ff[`SWC_F_PIN] == swc_pkg::SWC_COND) && pin_wake_irq
    |-> wk_pin_w == irq_enable_second[`SWC_IEN_PIN])
    else $error("Pin wake qualification wrong.");

  a_misc_rsvd: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wss_ff[`SWC_F_MISC] == swc_pkg::SWC_RSVD) |-> !wk_misc_w)
    else $error("Reserved misc code produced a wake.");

  a_run_nowake: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !standby_w && !enter_sb_w |=> !standby_w && !$rose(ist_ff[0]))
    else $error("Wake logic acted outside standby.");

  a_misc_source: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && (fast_crystal_osc_ready || adc_data_ready || rng_ready)
    |=> misc_irq_a)
    else $error("Misc interrupt missing after source event.");

  a_pin_absent: assert property (
    @(posedge pclk) disable iff (!presetn)
    (({pwh_ff, pwl_ff} & pin_mask_w) == 16'h0000) && !spi_wk_w
    |-> !pin_hit_w)
    else $error("Absent pin caused a wakeup.");

  a_pin_polarity: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !low_pol_w && !spi_wk_w && ((pin_en_w & wake_pins) != 16'h0000)
    |=> pin_wake_irq)
    else $error("High pin level did not wake.");

  a_spi_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && serial_slave_control_first[`SWC_SPI_EN] &&
    !serial_slave_select_n |=> pin_wake_irq)
    else $error("Serial select did not raise pin wakeup.");

  a_flag_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && rd_w && hit_pdc && !comparator_wake && !standby_w
    |=> pd_stat_ff == `SWC_RST3)
    else $error("Wake flags not cleared by read.");

  a_wake_exit: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && wake_w |=> !cpu_clk_stop ##0 ist_ff[`SWC_EV_WAKE])
    else $error("Qualified wake did not restart clock.");

endmodule
`default_nettype wire

// ==== verilog/swc_defines.svh ====
// Register indices, field positions, codes and masks of the wakeup control.
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define SWC_ADDR_W       10
`define SWC_IDX_PDC      8'ha4
`define SWC_IDX_WSS      8'ha5
`define SWC_IDX_OMC      8'hae
`define SWC_IDX_PWH      8'hce
`define SWC_IDX_PWL      8'hcf
`define SWC_IDX_IST      8'he0
`define SWC_IDX_IEN      8'he1
`define SWC_IDX_ICL      8'he2

// Reset values and readable masks.
`define SWC_RST8         8'h00
`define SWC_RST3         3'h0
`define SWC_OMC_MASK     8'h07

// Wake source select fields.
`define SWC_F_RADIO      7:6
`define SWC_F_TICK       5:4
`define SWC_F_PIN        3:2
`define SWC_F_MISC       1:0

// Bit positions in the second interrupt enable register.
`define SWC_IEN_RADIO    1
`define SWC_IEN_TICK     5
`define SWC_IEN_PIN      3
`define SWC_IEN_MISC     4

// Operating mode polarity bit and serial slave enable bit.
`define SWC_OMC_POL      2
`define SWC_SPI_EN       0

// Power-down register layout and modes.
`define SWC_PDC_STAT     7:5
`define SWC_PDC_MODE     2:0
`define SWC_MODE_NONE    3'h0
`define SWC_MODE_STANDBY 3'h7

// Status bits inside the power-down flag group.
`define SWC_ST_PIN       2
`define SWC_ST_TICK      1
`define SWC_ST_COMP      0

// Interrupt event bits.
`define SWC_EV_WAKE      0
`define SWC_EV_PIN       1
`define SWC_EV_MISC      2

// Wake pin presence and selectable polarity per package variant.
`define SWC_PMASK_BIG    16'hffff
`define SWC_PMASK_MID    16'h7fff
`define SWC_PMASK_SMALL  16'h007f
`define SWC_POL_BIG      16'h0044
`define SWC_POL_MID      16'h1444
`define SWC_POL_SMALL    16'h0040

`endif

// ==== verilog/swc_pkg.sv ====
// Types shared by the standby wakeup control.
`default_nettype none
package swc_pkg;

  // Wake source field codes.
  typedef enum logic [1:0] {
    SWC_COND   = 2'b00,
    SWC_RSVD   = 2'b01,
    SWC_ALWAYS = 2'b10,
    SWC_IGNORE = 2'b11
  } swc_code_e;

  // Package variants, largest first.
  typedef enum logic [1:0] {
    SWC_PKG_BIG   = 2'b00,
    SWC_PKG_MID   = 2'b01,
    SWC_PKG_SMALL = 2'b10
  } swc_variant_e;

  // Processor clock state.
  typedef enum logic {
    SWC_RUN     = 1'b0,
    SWC_STANDBY = 1'b1
  } swc_state_e;

endpackage
`default_nettype wire

// ==== verif/swc_src_model.sv ====
// Model of the on-chip event sources and external wake pins.
`timescale 1ns/10ps
`default_nettype none

module swc_src_model (
  input  wire logic        pclk,
  output logic             radio_irq,
  output logic             tick_pulse,
  output logic [15:0]      wake_pins,
  output logic             serial_slave_select_n,
  output logic             fast_crystal_osc_ready,
  output logic             adc_data_ready,
  output logic             rng_ready,
  output logic             comparator_wake
);

  logic [6:0]  ev;
  logic [15:0] pins;
  logic        csn;

  // Sources rest low; the select line rests high, so nothing is selected.
  initial begin
    ev = 7'h00;
    pins = 16'h0000;
    csn = 1'b1;
  end

  // An event lasts one clock and is launched just after an edge.
  task automatic pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev[k] <= 1'b0;
  endtask

  // Pin levels change only after an edge, never on it.
  task automatic set_pins(input logic [15:0] p, input logic c);
    @(posedge pclk);
    pins <= p;
    csn <= c;
  endtask

  // Event 0 radio, 1 tick, 2 pin 0, 3..5 misc sources, 6 comparator.
  assign radio_irq              = ev[0];
  assign tick_pulse             = ev[1];
  assign wake_pins              = pins | {15'h0000, ev[2]};
  assign serial_slave_select_n  = csn;
  assign fast_crystal_osc_ready = ev[3];
  assign adc_data_ready         = ev[4];
  assign rng_ready              = ev[5];
  assign comparator_wake        = ev[6];

endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench of the standby wakeup control.
`timescale 1ns/10ps
`include "swc_defines.svh"
`default_nettype none

module tb;

  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  ien;
  logic [7:0]  spi_ctl;
  logic        radio;
  logic        tick;
  logic [15:0] pins;
  logic        ssn;
  logic        osc;
  logic        adc;
  logic        rng;
  logic        cmp;
  logic        misc_irq;
  logic        pin_irq;
  logic        clk_stop;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          compares;
  int          cyc;

  localparam logic [1:0] CODES [5] = '{2'b00, 2'b00, 2'b10, 2'b11, 2'b01};
  localparam logic       IENV [5]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  localparam int         IENP [4]  = '{`SWC_IEN_RADIO, `SWC_IEN_TICK,
                                       `SWC_IEN_PIN, `SWC_IEN_MISC};
  localparam int         EVK [4]   = '{0, 1, 2, 5};
  localparam logic [7:0] FLAG [4]  = '{8'h07, 8'h47, 8'h87, 8'h07};

  swc_wakeup_ctrl #(.PKG_VARIANT(swc_pkg::SWC_PKG_BIG)) u_swc_wakeup_ctrl (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_enable_second(ien), .serial_slave_control_first(spi_ctl),
    .serial_slave_select_n(ssn), .wake_pins(pins), .radio_irq(radio),
    .tick_pulse(tick), .comparator_wake(cmp),
    .fast_crystal_osc_ready(osc), .adc_data_ready(adc), .rng_ready(rng),
    .misc_irq_a(misc_irq), .pin_wake_irq(pin_irq),
    .cpu_clk_stop(clk_stop), .irq(irq));

  swc_src_model u_swc_src_model (
    .pclk(pclk), .radio_irq(radio), .tick_pulse(tick), .wake_pins(pins),
    .serial_slave_select_n(ssn), .fast_crystal_osc_ready(osc),
    .adc_data_ready(adc), .rng_ready(rng), .comparator_wake(cmp));

  // ***********************************************************
  // Checks, bus cycles and closing
  // ***********************************************************

  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // The request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk_data(rd, {24'h000000, exp});
  endtask

  // Samples land a little after the edge so its updates have settled.
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic pin_case(input logic [15:0] en, input logic [7:0] om,
                          input logic [15:0] p, input logic c,
                          input logic s, input logic exp);
    apb(1'b1, `SWC_IDX_PWH, en[15:8]);
    apb(1'b1, `SWC_IDX_PWL, en[7:0]);
    apb(1'b1, `SWC_IDX_OMC, om);
    @(posedge pclk);
    spi_ctl <= {7'h00, s};
    u_swc_src_model.set_pins(p, c);
    cyc_wait(3);
    chk_bit(pin_irq, exp);
  endtask

  // ***********************************************************
  // Clock, watchdog and test sequence
  // ***********************************************************

  // A 25 ns clock period.
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // A hung handshake must not stall the run forever.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end

  // Reset, then walk the register bank, wake codes, interrupt and pins.
  initial begin
    logic [7:0] w;
    logic [7:0] nv;
    logic       woke;
    presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 10'h000; pwdata = 32'h0; ien = 8'h00;
    spi_ctl = 8'h00; fail_count = 0; compares = 0; cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`SWC_IDX_WSS, 8'h00);
    rchk(`SWC_IDX_PWH, 8'h00);
    rchk(`SWC_IDX_PWL, 8'h00);
    rchk(`SWC_IDX_OMC, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk_bit(err, 1'b1);
    apb(1'b1, `SWC_IDX_PWH, 8'ha5);
    rchk(`SWC_IDX_PWH, 8'ha5);
    apb(1'b1, `SWC_IDX_OMC, 8'hff);
    rchk(`SWC_IDX_OMC, 8'h07);
    apb(1'b1, `SWC_IDX_OMC, 8'h00);
    apb(1'b1, `SWC_IDX_PWH, 8'h00);
    apb(1'b1, `SWC_IDX_PWL, 8'h01);
    apb(1'b1, `SWC_IDX_IEN, 8'h01);
    apb(1'b1, `SWC_IDX_WSS, 8'hbf);
    u_swc_src_model.pulse(0);
    cyc_wait(4);
    chk_bit(clk_stop, 1'b0);
    rchk(`SWC_IDX_IST, 8'h00);
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 5; c++) begin
        woke = (CODES[c] == 2'b10) || (CODES[c] == 2'b00 && IENV[c]);
        nv = 8'h00;
        nv[IENP[s]] = IENV[c];
        w = 8'hff;
        w[6 - 2 * s +: 2] = CODES[c];
        @(posedge pclk);
        ien <= nv;
        apb(1'b1, `SWC_IDX_WSS, w);
        apb(1'b1, `SWC_IDX_PDC, 8'h07);
        cyc_wait(2);
        chk_bit(clk_stop, 1'b1);
        u_swc_src_model.pulse(EVK[s]);
        cyc_wait(4);
        chk_bit(clk_stop, !woke);
        if (woke) begin
          rchk(`SWC_IDX_PDC, FLAG[s]);
          rchk(`SWC_IDX_PDC, 8'h07);
          chk_bit(irq, 1'b1);
        end else begin
          apb(1'b1, `SWC_IDX_WSS, 8'hbf);
          u_swc_src_model.pulse(0);
          cyc_wait(4);
          chk_bit(clk_stop, 1'b0);
        end
        apb(1'b1, `SWC_IDX_ICL, 8'h07);
      end
    end
    apb(1'b1, `SWC_IDX_IEN, 8'h00);
    apb(1'b1, `SWC_IDX_PDC, 8'h07);
    u_swc_src_model.pulse(0);
    cyc_wait(4);
    chk_bit(irq, 1'b0);
    rchk(`SWC_IDX_IST, 8'h01);
    apb(1'b1, `SWC_IDX_IEN, 8'h01);
    cyc_wait(1);
    chk_bit(irq, 1'b1);
    apb(1'b1, `SWC_IDX_ICL, 8'h01);
    cyc_wait(1);
    chk_bit(irq, 1'b0);
    rchk(`SWC_IDX_IST, 8'h00);
    rchk(`SWC_IDX_ICL, 8'h00);
    for (int k = 3; k < 6; k++) begin
      u_swc_src_model.pulse(k);
      #1;
      chk_bit(misc_irq, 1'b1);
      cyc_wait(1);
      chk_bit(misc_irq, 1'b0);
    end
    // The misc events above leave only their own status bit set.
    rchk(`SWC_IDX_IST, 8'h04);
    // The comparator flag sets outside standby and clears on read.
    u_swc_src_model.pulse(6);
    cyc_wait(1);
    rchk(`SWC_IDX_PDC, 8'h27);
    rchk(`SWC_IDX_PDC, 8'h07);
    pin_case(16'h0004, 8'h04, 16'h0000, 1'b1, 1'b0, 1'b1);
    pin_case(16'h0004, 8'h04, 16'h0004, 1'b1, 1'b0, 1'b0);
    pin_case(16'h0004, 8'h00, 16'h0004, 1'b1, 1'b0, 1'b1);
    pin_case(16'h0008, 8'h04, 16'h0000, 1'b1, 1'b0, 1'b0);
    pin_case(16'h8000, 8'h00, 16'h8000, 1'b1, 1'b0, 1'b1);
    pin_case(16'h0000, 8'h00, 16'h8000, 1'b1, 1'b0, 1'b0);
    pin_case(16'h0000, 8'h00, 16'h0000, 1'b0, 1'b1, 1'b1);
    pin_case(16'h0000, 8'h00, 16'h0000, 1'b1, 1'b1, 1'b0);
    pin_case(16'h0000, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0);
    finish_test();
  end

endmodule
`default_nettype wire
